// ===== hdl/pbc_cfg.svh
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH

// Register indexes seen through the indirect access port
`define PBC_IDX_CTRL       5'h00
`define PBC_IDX_STAT       5'h01
`define PBC_IDX_ID1        5'h02
`define PBC_IDX_ID2        5'h03
`define PBC_IDX_ADV        5'h04
`define PBC_IDX_LPA        5'h05
`define PBC_IDX_EXP        5'h06
`define PBC_IDX_MODE       5'h11
`define PBC_IDX_SPMODE     5'h12
`define PBC_IDX_SPIND      5'h1b
`define PBC_IDX_ISRC       5'h1d
`define PBC_IDX_IMASK      5'h1e
`define PBC_IDX_SPCTL      5'h1f

// Basic control field positions
`define PBC_CTRL_RESET     15
`define PBC_CTRL_LOOP      14
`define PBC_CTRL_SPEED     13
`define PBC_CTRL_ANEG      12
`define PBC_CTRL_PDOWN     11
`define PBC_CTRL_RESTART   9
`define PBC_CTRL_DUPLEX    8
`define PBC_CTRL_COLTEST   7

// Stored, readable and kept bit masks; reserved bits are never stored
`define PBC_CTRL_STORE_MASK 16'h7980
`define PBC_CTRL_READ_MASK  16'hfb80
`define PBC_CTRL_KEPT_MASK  16'h0000

// Basic status: fixed ability bits and dynamic field positions
`define PBC_STAT_FIXED     16'h7809
`define PBC_STAT_ANEG_DONE 5
`define PBC_STAT_LINK      2

// Arbitrary identifier values
`define PBC_ID1_VALUE      16'h1234
`define PBC_ID2_VALUE      16'h5678

// Timing
`define PBC_CLK_PERIOD_NS  10
`define PBC_SRST_TIME_NS   1000
`define PBC_SRST_CYCLES    ((`PBC_SRST_TIME_NS + `PBC_CLK_PERIOD_NS - 1) / `PBC_CLK_PERIOD_NS)

`endif

// ===== hdl/pbc_pkg.sv
`include "pbc_cfg.svh"

package pbc_pkg;
    typedef logic [4:0]  pbc_idx_t;
    typedef logic [15:0] pbc_word_t;

    typedef enum logic [4:0] {
        PBC_REG_CTRL   = `PBC_IDX_CTRL,
        PBC_REG_STAT   = `PBC_IDX_STAT,
        PBC_REG_ID1    = `PBC_IDX_ID1,
        PBC_REG_ID2    = `PBC_IDX_ID2,
        PBC_REG_ADV    = `PBC_IDX_ADV,
        PBC_REG_LPA    = `PBC_IDX_LPA,
        PBC_REG_EXP    = `PBC_IDX_EXP,
        PBC_REG_MODE   = `PBC_IDX_MODE,
        PBC_REG_SPMODE = `PBC_IDX_SPMODE,
        PBC_REG_SPIND  = `PBC_IDX_SPIND,
        PBC_REG_ISRC   = `PBC_IDX_ISRC,
        PBC_REG_IMASK  = `PBC_IDX_IMASK,
        PBC_REG_SPCTL  = `PBC_IDX_SPCTL
    } pbc_reg_e;

    typedef enum logic [0:0] {
        PBC_SRST_IDLE = 1'b0,
        PBC_SRST_BUSY = 1'b1
    } pbc_srst_e;
endpackage

// ===== hdl/pbc_srst_timer.sv
`timescale 1ns/1ns
`include "pbc_cfg.svh"

module pbc_srst_timer #(
    parameter int unsigned CYCLES = `PBC_SRST_CYCLES
) (
    input  wire logic sys_clk, // System clock
    input  wire logic nrst,    // Synchronous reset, active low
    input  wire logic start,   // Begin a soft reset
    output logic      busy,    // Soft reset in progress
    output logic      done     // Last busy cycle
);
    import pbc_pkg::*;

    localparam int unsigned CW = $clog2(CYCLES + 1);

    pbc_srst_e     stateQ;
    pbc_srst_e     stateD;
    logic [CW-1:0] cntQ;
    logic [CW-1:0] cntD;
    wire           lastCycle = (cntQ == CW'(CYCLES - 1));

    always_comb begin
        stateD = stateQ;
        cntD   = cntQ;
        case (stateQ)
            PBC_SRST_IDLE: begin
                cntD = '0;
                if (start) begin
                    stateD = PBC_SRST_BUSY;
                end
            end
            PBC_SRST_BUSY: begin
                cntD = cntQ + CW'(1);
                if (lastCycle) begin
                    stateD = PBC_SRST_IDLE;
                end
            end
            default: begin
                stateD = PBC_SRST_IDLE;
                cntD   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            stateQ <= PBC_SRST_IDLE;
            cntQ   <= '0;
        end else begin
            stateQ <= stateD;
            cntQ   <= cntD;
        end
    end

    assign busy = (stateQ == PBC_SRST_BUSY);
    assign done = busy & lastCycle;
endmodule

// ===== hdl/pbc_regs.sv
`timescale 1ns/1ns
`include "pbc_cfg.svh"

module pbc_regs #(
    parameter int unsigned        SRST_CYCLES = `PBC_SRST_CYCLES,
    parameter pbc_pkg::pbc_word_t KEPT_MASK   = `PBC_CTRL_KEPT_MASK,
    parameter pbc_pkg::pbc_word_t ID1_VALUE   = `PBC_ID1_VALUE, // Arbitrary value
    parameter pbc_pkg::pbc_word_t ID2_VALUE   = `PBC_ID2_VALUE  // Arbitrary value
) (
    input  wire logic              sys_clk,        // System clock
    input  wire logic              nrst,           // Synchronous reset, active low
    input  wire logic              accReq,         // Access request pulse
    input  wire logic              accWrite,       // 1 write, 0 read
    input  wire pbc_pkg::pbc_idx_t accIndex,       // Register index
    input  wire pbc_pkg::pbc_word_t accWrData,     // Write data
    output pbc_pkg::pbc_word_t     accRdData,      // Read data
    output logic                   accAck,         // Access answered
    output logic                   accUnmapped,    // Index not decoded
    input  wire logic              speedStrap,     // Speed-select strap level
    input  wire logic              anegDoneIn,     // Negotiation engine completed
    input  wire logic              anegSpeed100In, // Negotiated speed
    input  wire logic              anegFullDupIn,  // Negotiated duplex
    input  wire logic              linkUpIn,       // Link status
    output logic                   phySoftReset,   // Soft reset in progress
    output logic                   loopbackEn,     // Loopback mode
    output logic                   anegEnable,     // Auto-negotiation enabled
    output logic                   anegRestart,    // Restart negotiation pulse
    output logic                   powerDown,      // General power-down
    output logic                   colTestEn,      // Collision test
    output logic                   linkSpeed100,   // Effective speed
    output logic                   linkFullDup     // Effective duplex
);
    import pbc_pkg::*;

    function automatic logic isMapped(input pbc_idx_t idx);
        case (idx)
            PBC_REG_CTRL, PBC_REG_STAT, PBC_REG_ID1, PBC_REG_ID2,
            PBC_REG_ADV, PBC_REG_LPA, PBC_REG_EXP, PBC_REG_MODE,
            PBC_REG_SPMODE, PBC_REG_SPIND, PBC_REG_ISRC,
            PBC_REG_IMASK, PBC_REG_SPCTL: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    pbc_word_t ctrlQ;
    pbc_word_t ctrlD;
    logic      restartQ;
    logic      anegCompleteQ;
    logic      speedQ;
    logic      duplexQ;
    logic      srstBusy;
    logic      srstDone;

    // Host writes only land when the soft reset is not running
    wire       ctrlSel   = (accIndex == pbc_idx_t'(`PBC_IDX_CTRL));
    wire       ctrlWr    = accReq & accWrite & ctrlSel & ~srstBusy;
    wire       srstStart = ctrlWr & accWrData[`PBC_CTRL_RESET];
    wire       restartWr = ctrlWr & accWrData[`PBC_CTRL_RESTART] & ~srstStart;

    // Speed and auto-negotiation power up from the strap
    wire pbc_word_t ctrlDefault = {2'b00, speedStrap, speedStrap, 12'h000};

    // Soft reset reloads defaults except for kept fields
    wire pbc_word_t ctrlSoft = ((ctrlQ & KEPT_MASK) | (ctrlDefault & ~KEPT_MASK))
                               & `PBC_CTRL_STORE_MASK;

    assign ctrlD = srstStart ? ctrlSoft
                 : ctrlWr    ? (accWrData & `PBC_CTRL_STORE_MASK)
                 : ctrlQ;

    wire pbc_word_t ctrlRead = ctrlQ
                             | (pbc_word_t'(srstBusy) << `PBC_CTRL_RESET)
                             | (pbc_word_t'(restartQ) << `PBC_CTRL_RESTART);

    wire pbc_word_t statRead = `PBC_STAT_FIXED
                             | (pbc_word_t'(anegCompleteQ) << `PBC_STAT_ANEG_DONE)
                             | (pbc_word_t'(linkUpIn) << `PBC_STAT_LINK);

    // Registers owned by other blocks read as zero here
    wire pbc_word_t readMux = (accIndex == pbc_idx_t'(`PBC_IDX_CTRL)) ? ctrlRead
                            : (accIndex == pbc_idx_t'(`PBC_IDX_STAT)) ? statRead
                            : (accIndex == pbc_idx_t'(`PBC_IDX_ID1))  ? ID1_VALUE
                            : (accIndex == pbc_idx_t'(`PBC_IDX_ID2))  ? ID2_VALUE
                            : 16'h0000;

    wire anegOn     = ctrlQ[`PBC_CTRL_ANEG];
    wire pdownOn    = ctrlQ[`PBC_CTRL_PDOWN];
    wire anegSet    = anegDoneIn & anegOn & ~pdownOn & ~srstBusy;
    wire anegClear  = restartQ | srstBusy | ~anegOn | pdownOn;
    // Manual speed and duplex give way to negotiated values
    wire speedNext  = anegOn ? anegSpeed100In : ctrlQ[`PBC_CTRL_SPEED];
    wire duplexNext = anegOn ? anegFullDupIn  : ctrlQ[`PBC_CTRL_DUPLEX];

    pbc_srst_timer #(
        .CYCLES (SRST_CYCLES)
    ) u_srst (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .start   (srstStart),
        .busy    (srstBusy),
        .done    (srstDone)
    );

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrlQ <= ctrlDefault & `PBC_CTRL_STORE_MASK;
        end else begin
            ctrlQ <= ctrlD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            restartQ <= 1'b0;
        end else begin
            restartQ <= restartWr;
        end
    end

    // Completion wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            anegCompleteQ <= 1'b0;
        end else if (anegSet) begin
            anegCompleteQ <= 1'b1;
        end else if (anegClear) begin
            anegCompleteQ <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            accAck      <= 1'b0;
            accRdData   <= 16'h0000;
            accUnmapped <= 1'b0;
            speedQ      <= 1'b0;
            duplexQ     <= 1'b0;
        end else begin
            accAck      <= accReq;
            accRdData   <= (accReq & ~accWrite) ? readMux : accRdData;
            accUnmapped <= accReq & ~isMapped(accIndex);
            speedQ      <= speedNext;
            duplexQ     <= duplexNext;
        end
    end

    assign phySoftReset = srstBusy;
    assign loopbackEn   = ctrlQ[`PBC_CTRL_LOOP];
    assign anegEnable   = anegOn;
    assign anegRestart  = restartQ;
    assign powerDown    = pdownOn;
    assign colTestEn    = ctrlQ[`PBC_CTRL_COLTEST];
    assign linkSpeed100 = speedQ;
    assign linkFullDup  = duplexQ;

    // Checks
    localparam int SrstBound = SRST_CYCLES + 1;
    localparam pbc_word_t StatDynMask = (16'h0001 << `PBC_STAT_ANEG_DONE)
                                      | (16'h0001 << `PBC_STAT_LINK);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence seq_srst_run;
        srstBusy ##[1:SrstBound] !srstBusy;
    endsequence

    sequence seq_restart_pulse;
        anegRestart ##1 !anegRestart;
    endsequence

    sequence seq_ctrl_read;
        accReq && !accWrite && ctrlSel;
    endsequence

    sequence seq_stat_read;
        accReq && !accWrite && (accIndex == pbc_idx_t'(`PBC_IDX_STAT));
    endsequence

    sequence seq_busy_write;
        accReq && accWrite && ctrlSel && srstBusy;
    endsequence

    a_ack_next_cycle: assert property (
        accReq |=> accAck
    ) else $error("access not answered in one cycle");

    a_unmapped_flag: assert property (
        accReq && !isMapped(accIndex) && !accWrite |=> accUnmapped && accRdData == 16'h0000
    ) else $error("unmapped index answered wrongly");

    a_mapped_flag: assert property (
        accReq && isMapped(accIndex) |=> !accUnmapped
    ) else $error("mapped index flagged as unmapped");

    a_ctrl_reserved: assert property (
        accReq && !accWrite && ctrlSel |=> (accRdData & ~`PBC_CTRL_READ_MASK) == 16'h0000
    ) else $error("reserved control bits read nonzero");

    a_srst_self_clear: assert property (
        srstStart |=> seq_srst_run
    ) else $error("soft reset bit did not self clear");

    a_srst_defaults: assert property (
        srstStart |=> ((ctrlQ ^ $past(ctrlSoft)) & `PBC_CTRL_STORE_MASK) == 16'h0000
    ) else $error("soft reset did not reload defaults");

    a_write_fields: assert property (
        ctrlWr && !accWrData[`PBC_CTRL_RESET]
        |=> ctrlQ == ($past(accWrData) & `PBC_CTRL_STORE_MASK) && !srstBusy
    ) else $error("control write not stored");

    a_restart_pulse: assert property (
        restartWr |=> seq_restart_pulse
    ) else $error("restart not a single pulse");

    a_aneg_override: assert property (
        anegOn |=> linkSpeed100 == $past(anegSpeed100In) && linkFullDup == $past(anegFullDupIn)
    ) else $error("manual speed or duplex used under negotiation");

    a_manual_mode: assert property (
        !anegOn |=> linkSpeed100 == $past(ctrlQ[`PBC_CTRL_SPEED])
                 && linkFullDup == $past(ctrlQ[`PBC_CTRL_DUPLEX])
    ) else $error("manual speed or duplex not applied");

    a_aneg_complete: assert property (
        anegSet |=> anegCompleteQ
    ) else $error("negotiation completion not recorded");

    a_pdown_clears: assert property (
        pdownOn && !anegSet |=> !anegCompleteQ
    ) else $error("completion kept during power down");

    a_srst_done_end: assert property (
        srstDone |=> !srstBusy
    ) else $error("soft reset outlived its count");

    a_strap_defaults: assert property (
        $rose(nrst) |-> ctrlQ[`PBC_CTRL_SPEED] == $past(speedStrap)
                     && ctrlQ[`PBC_CTRL_ANEG] == $past(speedStrap)
    ) else $error("speed or negotiation default not from strap");

    a_reset_quiet: assert property (
        $rose(nrst) |-> !loopbackEn && !powerDown && !colTestEn
                     && !anegRestart && !phySoftReset && !accAck
    ) else $error("outputs not at reset values");

    a_srst_drops_write: assert property (
        seq_busy_write |=> ctrlQ == $past(ctrlQ)
    ) else $error("control write landed during soft reset");

    a_restart_source: assert property (
        anegRestart |-> $past(restartWr)
    ) else $error("restart pulse without a restart write");

    a_stat_aneg_bit: assert property (
        seq_stat_read |=> accRdData[`PBC_STAT_ANEG_DONE] == $past(anegCompleteQ)
    ) else $error("status completion bit wrong");

    a_ctrl_busy_bit: assert property (
        seq_ctrl_read |=> accRdData[`PBC_CTRL_RESET] == $past(srstBusy)
    ) else $error("reset bit does not show soft reset");

    a_aneg_off_clears: assert property (
        !anegOn |=> !anegCompleteQ
    ) else $error("completion kept with negotiation off");

    a_rdata_hold: assert property (
        !(accReq && !accWrite) |=> $stable(accRdData)
    ) else $error("read data changed without a read");

    a_ack_pulse: assert property (
        !accReq |=> !accAck
    ) else $error("answer without a request");

    a_kept_fields: assert property (
        srstStart
        |=> ((ctrlQ ^ $past(ctrlQ)) & KEPT_MASK & `PBC_CTRL_STORE_MASK) == 16'h0000
    ) else $error("kept field changed by soft reset");

    a_stat_fixed: assert property (
        seq_stat_read |=> accRdData[`PBC_STAT_LINK] == $past(linkUpIn)
                       && (accRdData & ~StatDynMask) == `PBC_STAT_FIXED
    ) else $error("status fixed or link bits wrong");

    a_id_values: assert property (
        accReq && !accWrite && (accIndex == pbc_idx_t'(`PBC_IDX_ID1))
        |=> accRdData == ID1_VALUE
    ) else $error("identifier one read wrongly");

    a_srst_no_restart: assert property (
        srstStart |=> !anegRestart
    ) else $error("restart pulse during soft reset start");

    a_write_outputs: assert property (
        ctrlWr && !accWrData[`PBC_CTRL_RESET]
        |=> loopbackEn == $past(accWrData[`PBC_CTRL_LOOP])
            && powerDown == $past(accWrData[`PBC_CTRL_PDOWN])
            && colTestEn == $past(accWrData[`PBC_CTRL_COLTEST])
    ) else $error("mode outputs not following control write");
endmodule

// ===== tb/pbc_mac_model.sv
`timescale 1ns/1ns
module pbc_mac_model (
    input  wire logic               sys_clk,     // System clock
    output logic                    accReq,      // Access request pulse
    output logic                    accWrite,    // 1 write, 0 read
    output pbc_pkg::pbc_idx_t       accIndex,    // Register index
    output pbc_pkg::pbc_word_t      accWrData,   // Write data
    input  wire pbc_pkg::pbc_word_t accRdData,   // Read data
    input  wire logic               accAck,      // Access answered
    input  wire logic               accUnmapped  // Index not decoded
);
    import pbc_pkg::*;

    initial begin
        accReq    = 1'b0;
        accWrite  = 1'b0;
        accIndex  = 5'h00;
        accWrData = 16'h0000;
    end

    // One pulse per access; released index and data lines flip so stale data never looks valid
    task automatic xfer(input logic wr, input pbc_idx_t idx, input pbc_word_t wd,
                        output pbc_word_t rd, output logic unm, output logic ack);
        int n;
        n = 0;
        @(posedge sys_clk) #1;
        accReq    = 1'b1;
        accWrite  = wr;
        accIndex  = idx;
        accWrData = wd;
        @(posedge sys_clk) #1;
        accReq    = 1'b0;
        accIndex  = ~idx;
        accWrData = ~wd;
        while (accAck !== 1'b1 && n < 4) begin
            @(posedge sys_clk) #1;
            n++;
        end
        ack = accAck;
        rd  = accRdData;
        unm = accUnmapped;
    endtask
endmodule

// ===== tb/pbc_regs_tb.sv
`timescale 1ns/1ns
module pbc_regs_tb;
    import pbc_pkg::*;
    localparam int unsigned SRST = 6;
    localparam pbc_word_t   ID1  = 16'h0a0b; // Arbitrary value
    localparam pbc_word_t   ID2  = 16'h0c0d; // Arbitrary value
    logic      sys_clk, nrst, accReq, accWrite, accAck, accUnmapped, speedStrap;
    logic      anegDoneIn, anegSpeed100In, anegFullDupIn, linkUpIn, phySoftReset;
    logic      loopbackEn, anegEnable, anegRestart, powerDown, colTestEn;
    logic      linkSpeed100, linkFullDup, unm;
    pbc_idx_t  accIndex;
    pbc_word_t accWrData, accRdData, rd;
    int        errCount = 0;
    int        checks = 0;

    pbc_regs #(.SRST_CYCLES(SRST), .KEPT_MASK(16'h0000), .ID1_VALUE(ID1),
               .ID2_VALUE(ID2)) i_pbc_regs (
        .sys_clk(sys_clk), .nrst(nrst), .accReq(accReq), .accWrite(accWrite),
        .accIndex(accIndex), .accWrData(accWrData), .accRdData(accRdData),
        .accAck(accAck), .accUnmapped(accUnmapped), .speedStrap(speedStrap),
        .anegDoneIn(anegDoneIn), .anegSpeed100In(anegSpeed100In),
        .anegFullDupIn(anegFullDupIn), .linkUpIn(linkUpIn), .phySoftReset(phySoftReset),
        .loopbackEn(loopbackEn), .anegEnable(anegEnable), .anegRestart(anegRestart),
        .powerDown(powerDown), .colTestEn(colTestEn), .linkSpeed100(linkSpeed100),
        .linkFullDup(linkFullDup));

    pbc_mac_model i_pbc_mac_model (
        .sys_clk(sys_clk), .accReq(accReq), .accWrite(accWrite), .accIndex(accIndex),
        .accWrData(accWrData), .accRdData(accRdData), .accAck(accAck),
        .accUnmapped(accUnmapped));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic acc(input logic wr, input pbc_idx_t idx, input pbc_word_t wd);
        logic ack;
        i_pbc_mac_model.xfer(wr, idx, wd, rd, unm, ack);
        chk("accAck", {15'h0, ack}, 16'h0001);
        if (ack !== 1'b1) begin
            end_sim();
        end
    endtask

    task automatic t_reset;
        acc(1'b0, 5'h00, 16'h0000);
        chk("ctrl reset", rd, 16'h3000);
        chk("outputs", {loopbackEn, anegEnable, powerDown, colTestEn}, 4'b0100);
        $display("test reset done");
    endtask

    task automatic t_fields;
        acc(1'b1, 5'h00, 16'h6dff);
        chk("modes", {loopbackEn, powerDown, colTestEn, anegEnable}, 4'b1110);
        acc(1'b0, 5'h00, 16'h0000);
        chk("ctrl back", rd, 16'h6980);
        chk("manual link", {linkSpeed100, linkFullDup}, 2'b11);
        acc(1'b1, 5'h00, 16'h0100);
        acc(1'b0, 5'h00, 16'h0000);
        chk("ctrl back2", rd, 16'h0100);
        chk("manual link2", {linkSpeed100, linkFullDup}, 2'b01);
        $display("test fields done");
    endtask

    task automatic t_aneg;
        anegSpeed100In = 1'b1;
        acc(1'b1, 5'h00, 16'h1100);
        @(posedge sys_clk) #1;
        chk("aneg link", {linkSpeed100, linkFullDup}, 2'b10);
        anegDoneIn = 1'b1;
        linkUpIn   = 1'b1;
        @(posedge sys_clk) #1;
        anegDoneIn = 1'b0;
        acc(1'b1, 5'h01, 16'h0000);
        acc(1'b0, 5'h01, 16'h0000);
        chk("status done", rd, 16'h782d);
        acc(1'b1, 5'h00, 16'h1300);
        chk("restart", {15'h0, anegRestart}, 16'h0001);
        acc(1'b0, 5'h00, 16'h0000);
        chk("restart clr", rd, 16'h1100);
        acc(1'b0, 5'h01, 16'h0000);
        chk("status clr", rd, 16'h780d);
        $display("test aneg done");
    endtask

    task automatic t_srst;
        int n;
        n = 0;
        speedStrap = 1'b0;
        acc(1'b1, 5'h00, 16'h4000);
        acc(1'b1, 5'h00, 16'h8000);
        while (phySoftReset === 1'b1 && n < 40) begin
            @(posedge sys_clk) #1;
            n++;
        end
        chk("srst len", n[15:0], SRST[15:0]);
        acc(1'b1, 5'h00, 16'h8000);
        acc(1'b0, 5'h00, 16'h0000);
        chk("srst busy", rd, 16'h8000);
        acc(1'b1, 5'h00, 16'h4000);
        repeat (SRST) @(posedge sys_clk);
        acc(1'b0, 5'h00, 16'h0000);
        chk("srst after", rd, 16'h0000);
        chk("loop off", {15'h0, loopbackEn}, 16'h0000);
        $display("test soft reset done");
    endtask

    task automatic t_decode;
        logic exp;
        for (int i = 0; i < 32; i++) begin
            exp = !(i <= 6 || i == 17 || i == 18 || i == 27 || i >= 29);
            acc(1'b0, i[4:0], 16'h0000);
            chk("unmapped", {15'h0, unm}, {15'h0, exp});
            if (i == 2)
                chk("id1", rd, ID1);
        end
        acc(1'b1, 5'h03, 16'hffff);
        acc(1'b0, 5'h03, 16'h0000);
        chk("id2", rd, ID2);
        $display("test decode done");
    endtask

    initial begin
        nrst = 1'b0;
        speedStrap = 1'b1;
        anegDoneIn = 1'b0;
        anegSpeed100In = 1'b0;
        anegFullDupIn = 1'b0;
        linkUpIn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 nrst = 1'b1;
        t_reset();
        t_fields();
        t_aneg();
        t_srst();
        t_decode();
        end_sim();
    end
endmodule
